// File: usart_pkg.sv
package usart_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_ERRCNT = 8'h0c;
  localparam logic [7:0] OFF_THR = 8'h10;
  localparam logic [7:0] OFF_RHR = 8'h14;
  localparam logic [7:0] OFF_BAUD = 8'h18;
  localparam logic [7:0] OFF_TG = 8'h1c;
  localparam int CR_RX_EN = 4;
  localparam int CR_RX_DIS = 5;
  localparam int CR_TX_EN = 6;
  localparam int CR_TX_DIS = 7;
  localparam int CR_STAT_CLR = 8;
  localparam int CR_BRK_START = 9;
  localparam int CR_BRK_STOP = 10;
  localparam int CR_REP_CLR = 11;
  localparam int CR_NACK_CLR = 12;
  localparam int MR_MODE_LSB = 0;
  localparam int MR_SYNC = 8;
  localparam int MR_PAR_LSB = 9;
  localparam int MR_STOP2 = 12;
  localparam int MR_MSB_FIRST_SELECT = 16;
  localparam int MR_NACK_INHIBIT = 20;
  localparam int MR_REP_LSB = 24;
  localparam logic [3:0] MODE_HANDSHAKE = 4'h2;
  localparam logic [3:0] MODE_SC_T0 = 4'h4;
  localparam logic [3:0] MODE_SC_T1 = 4'h5;
  localparam logic [2:0] PAR_EVEN = 3'h0;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_NONE = 3'h4;
  localparam int SR_RX_READY = 0;
  localparam int SR_TX_FREE = 1;
  localparam int SR_RX_BRK = 2;
  localparam int SR_FRAME = 6;
  localparam int SR_PARITY = 7;
  localparam int SR_TX_EMPTY = 9;
  localparam int SR_REPEAT = 10;
  localparam int SR_NACK = 13;
  localparam int SR_CTS = 23;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [7:0] TG_RST = 8'h00;
  localparam logic [3:0] SAMPLE_TICK = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hf;
  localparam logic [7:0] BRK_HOLD_BITS = 8'h0c;
  localparam logic [7:0] BRK_LAST_BIT = 8'h0a;
  localparam logic [1:0] BRK_END_ASYNC = 2'h2;
  localparam logic [1:0] BRK_END_SYNC = 2'h1;
  localparam logic [7:0] ERR_MAX = 8'hff;
endpackage : usart_pkg

// File: baud_if.sv
`timescale 1ns/1ps
`default_nettype none
interface baud_if;
  logic [15:0] divisor;
  logic tick;
  logic sck;
  modport gen (input divisor, output tick, output sck);
  modport core (output divisor, input tick, input sck);
endinterface : baud_if
`default_nettype wire

// File: baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
module baud_gen (
  input wire logic clock,
  input wire logic resetn,
  baud_if.gen bif
);
  logic [15:0] cnt_r, cnt_nxt;
  logic tick_r, tick_nxt;
  logic sck_r, sck_nxt;

  // sixteen ticks per bit; card clock toggles on each tick
  always_comb begin
    cnt_nxt = cnt_r + 16'h0001;
    tick_nxt = 1'b0;
    sck_nxt = sck_r;
    if (bif.divisor == 16'h0000) begin
      cnt_nxt = 16'h0000;
    end else if (cnt_r >= bif.divisor - 16'h0001) begin
      cnt_nxt = 16'h0000;
      tick_nxt = 1'b1;
      sck_nxt = ~sck_r;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
      sck_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
      sck_r <= sck_nxt;
    end
  end

  assign bif.tick = tick_r;
  assign bif.sck = sck_r;
endmodule : baud_gen
`default_nettype wire

// File: usart_core.sv
`timescale 1ns/1ps
`default_nettype none
module usart_core
  import usart_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic txd_in,
  output logic txd_out,
  output logic txd_oe_n,
  output logic sck,
  output logic rts,
  input wire logic cts,
  input wire logic rx_dma_buffer_full
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_GUARD, TX_BRK,
    TX_HOLD} tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_NACK,
    RX_BRKEND} rx_state_type;

  baud_if bif ();
  baud_gen u_baud (.clock(clock), .resetn(resetn), .bif(bif));

  // input synchronisers
  logic rxd_s1_r, rxd_s2_r, txi_s1_r, txi_s2_r, cts_s1_r, cts_s2_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
      txi_s1_r <= 1'b1;
      txi_s2_r <= 1'b1;
      cts_s1_r <= 1'b1;
      cts_s2_r <= 1'b1;
    end else begin
      rxd_s1_r <= rxd;
      rxd_s2_r <= rxd_s1_r;
      txi_s1_r <= txd_in;
      txi_s2_r <= txi_s1_r;
      cts_s1_r <= cts;
      cts_s2_r <= cts_s1_r;
    end
  end

  logic rx_en_r, rx_en_nxt, tx_en_r, tx_en_nxt;
  logic [31:0] mode_r, mode_nxt;
  logic [15:0] baud_r, baud_nxt;
  logic [7:0] tg_r, tg_nxt, thr_r, thr_nxt, err_cnt_r, err_cnt_nxt;
  logic thr_full_r, thr_full_nxt, brk_req_r, brk_req_nxt, brk_stop_r, brk_stop_nxt;
  logic rx_rdy_r, rx_rdy_nxt, rx_brk_f_r, rx_brk_f_nxt, frame_f_r, frame_f_nxt;
  logic par_f_r, par_f_nxt, nack_f_r, nack_f_nxt, rep_f_r, rep_f_nxt;
  logic [31:0] prdata_r, prdata_nxt, cmd, stat;
  logic mapped;
  tx_state_type tx_st_r, tx_st_nxt;
  rx_state_type rx_st_r, rx_st_nxt;
  logic tx_load, brk_begin, brk_end, rep_evt;
  logic rx_rdy_set, brk_evt, frame_evt, par_evt, nack_inhibit_evt, err_evt;
  logic [7:0] rhr_r, rhr_nxt;

  // mode decode
  logic [3:0] mode_f;
  logic [2:0] par_sel, rep_lim;
  logic sc, t0, hs, par_en, odd, stop2, msb_first_select, nack_inhibit, sync;
  always_comb begin
    mode_f = mode_r[MR_MODE_LSB +: 4];
    sc = (mode_f == MODE_SC_T0) || (mode_f == MODE_SC_T1);
    t0 = (mode_f == MODE_SC_T0);
    hs = (mode_f == MODE_HANDSHAKE);
    par_sel = mode_r[MR_PAR_LSB +: 3];
    if (sc) begin
      par_sel = (par_sel == PAR_ODD) ? PAR_ODD : PAR_EVEN;
    end
    par_en = (par_sel != PAR_NONE);
    odd = (par_sel == PAR_ODD);
    stop2 = mode_r[MR_STOP2];
    msb_first_select = mode_r[MR_MSB_FIRST_SELECT];
    nack_inhibit = mode_r[MR_NACK_INHIBIT];
    sync = mode_r[MR_SYNC];
    rep_lim = mode_r[MR_REP_LSB +: 3];
  end

  // apb access decode
  logic acc, wr, rd, tx_free, tx_empty, brk_busy, start_ok, stop_ok;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign cmd = (wr && paddr == OFF_CTRL) ? pwdata : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_r;
  assign bif.divisor = baud_r;
  assign sck = bif.sck;

  assign tx_free = ~thr_full_r & ~brk_req_r;
  assign tx_empty = tx_free & (tx_st_r == TX_IDLE);
  assign brk_busy = brk_req_r | (tx_st_r == TX_BRK) | (tx_st_r == TX_HOLD);
  assign start_ok = cmd[CR_BRK_START] & tx_free & ~brk_busy;
  assign stop_ok = cmd[CR_BRK_STOP] & tx_free & (tx_st_r == TX_BRK);

  // register file
  always_comb begin
    rx_en_nxt = rx_en_r;
    tx_en_nxt = tx_en_r;
    if (cmd[CR_RX_EN]) rx_en_nxt = 1'b1;
    if (cmd[CR_RX_DIS]) rx_en_nxt = 1'b0;
    if (cmd[CR_TX_EN]) tx_en_nxt = 1'b1;
    if (cmd[CR_TX_DIS]) tx_en_nxt = 1'b0;
    mode_nxt = (wr && paddr == OFF_MODE) ? pwdata : mode_r;
    baud_nxt = (wr && paddr == OFF_BAUD) ? pwdata[15:0] : baud_r;
    tg_nxt = (wr && paddr == OFF_TG) ? pwdata[7:0] : tg_r;
    thr_nxt = thr_r;
    thr_full_nxt = thr_full_r & ~tx_load;
    if (wr && paddr == OFF_THR && !brk_req_r) begin
      thr_nxt = pwdata[7:0];
      thr_full_nxt = 1'b1;
    end
    brk_req_nxt = (brk_req_r & ~brk_begin) | start_ok;
    brk_stop_nxt = (brk_stop_r & ~brk_end) | stop_ok;
    rx_rdy_nxt = (rx_rdy_r & ~(rd && paddr == OFF_RHR)) | rx_rdy_set;
    rx_brk_f_nxt = (rx_brk_f_r & ~cmd[CR_STAT_CLR]) | brk_evt;
    frame_f_nxt = (frame_f_r & ~cmd[CR_STAT_CLR]) | frame_evt;
    par_f_nxt = (par_f_r & ~cmd[CR_STAT_CLR]) | par_evt;
    nack_f_nxt = (nack_f_r & ~cmd[CR_NACK_CLR]) | nack_inhibit_evt;
    rep_f_nxt = (rep_f_r & ~cmd[CR_REP_CLR]) | rep_evt;
    err_cnt_nxt = (rd && paddr == OFF_ERRCNT) ? 8'h00 : err_cnt_r;
    if (err_evt && err_cnt_nxt != ERR_MAX) begin
      err_cnt_nxt = err_cnt_nxt + 8'h01;
    end
    stat = 32'h0000_0000;
    stat[SR_RX_READY] = rx_rdy_r;
    stat[SR_TX_FREE] = tx_free;
    stat[SR_RX_BRK] = rx_brk_f_r;
    stat[SR_FRAME] = frame_f_r;
    stat[SR_PARITY] = par_f_r;
    stat[SR_TX_EMPTY] = tx_empty;
    stat[SR_REPEAT] = rep_f_r;
    stat[SR_NACK] = nack_f_r;
    stat[SR_CTS] = cts_s2_r;
    mapped = 1'b1;
    prdata_nxt = prdata_r;
    case (paddr)
      OFF_CTRL: prdata_nxt = 32'h0000_0000;
      OFF_MODE: prdata_nxt = mode_r;
      OFF_STAT: prdata_nxt = stat;
      OFF_ERRCNT: prdata_nxt = {24'h000000, err_cnt_r};
      OFF_THR: prdata_nxt = 32'h0000_0000;
      OFF_RHR: prdata_nxt = {24'h000000, rhr_r};
      OFF_BAUD: prdata_nxt = {16'h0000, baud_r};
      OFF_TG: prdata_nxt = {24'h000000, tg_r};
      default: begin
        mapped = 1'b0;
        prdata_nxt = 32'h0000_0000;
      end
    endcase
    if (!(psel && !penable)) prdata_nxt = prdata_r;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_en_r <= 1'b0;
      tx_en_r <= 1'b0;
      mode_r <= MODE_RST;
      baud_r <= BAUD_RST;
      tg_r <= TG_RST;
      thr_r <= 8'h00;
      thr_full_r <= 1'b0;
      brk_req_r <= 1'b0;
      brk_stop_r <= 1'b0;
      rx_rdy_r <= 1'b0;
      rx_brk_f_r <= 1'b0;
      frame_f_r <= 1'b0;
      par_f_r <= 1'b0;
      nack_f_r <= 1'b0;
      rep_f_r <= 1'b0;
      err_cnt_r <= 8'h00;
      prdata_r <= 32'h0000_0000;
    end else begin
      rx_en_r <= rx_en_nxt;
      tx_en_r <= tx_en_nxt;
      mode_r <= mode_nxt;
      baud_r <= baud_nxt;
      tg_r <= tg_nxt;
      thr_r <= thr_nxt;
      thr_full_r <= thr_full_nxt;
      brk_req_r <= brk_req_nxt;
      brk_stop_r <= brk_stop_nxt;
      rx_rdy_r <= rx_rdy_nxt;
      rx_brk_f_r <= rx_brk_f_nxt;
      frame_f_r <= frame_f_nxt;
      par_f_r <= par_f_nxt;
      nack_f_r <= nack_f_nxt;
      rep_f_r <= rep_f_nxt;
      err_cnt_r <= err_cnt_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // transmitter
  logic [3:0] tx_tk_r, tx_tk_nxt;
  logic [7:0] tx_bit_r, tx_bit_nxt, tx_char_r, tx_char_nxt, hold_last;
  logic [2:0] rep_cnt_r, rep_cnt_nxt;
  logic tx_par_r, tx_par_nxt, nack_seen_r, nack_seen_nxt, tx_end, tx_line, tx_drive;
  assign tx_end = bif.tick & (tx_tk_r == LAST_TICK);
  assign hold_last = ((tg_r > BRK_HOLD_BITS) ? tg_r : BRK_HOLD_BITS) - 8'h01;

  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_tk_nxt = bif.tick ? tx_tk_r + 4'h1 : tx_tk_r;
    tx_bit_nxt = tx_bit_r;
    tx_char_nxt = tx_char_r;
    tx_par_nxt = tx_par_r;
    rep_cnt_nxt = rep_cnt_r;
    nack_seen_nxt = nack_seen_r;
    tx_load = 1'b0;
    brk_begin = 1'b0;
    brk_end = 1'b0;
    rep_evt = 1'b0;
    case (tx_st_r)
      TX_IDLE: begin
        tx_tk_nxt = 4'h0;
        tx_bit_nxt = 8'h00;
        nack_seen_nxt = 1'b0;
        if (tx_en_r && brk_req_r) begin
          tx_st_nxt = TX_BRK;
          brk_begin = 1'b1;
        end else if (tx_en_r && thr_full_r && !(hs && cts_s2_r)) begin
          tx_load = 1'b1;
          tx_char_nxt = thr_r;
          tx_par_nxt = (^thr_r) ^ odd;
          rep_cnt_nxt = 3'h0;
          tx_st_nxt = TX_START;
        end
      end
      TX_START: if (tx_end) tx_st_nxt = TX_DATA;
      TX_DATA: if (tx_end) begin
        tx_bit_nxt = tx_bit_r + 8'h01;
        if (tx_bit_r[2:0] == 3'h7) begin
          tx_bit_nxt = 8'h00;
          tx_st_nxt = par_en ? TX_PAR : TX_STOP;
        end
      end
      TX_PAR: if (tx_end) tx_st_nxt = t0 ? TX_GUARD : TX_STOP;
      TX_STOP: if (tx_end) begin
        tx_bit_nxt = tx_bit_r + 8'h01;
        if (tx_bit_r == (stop2 ? 8'h01 : 8'h00)) tx_st_nxt = TX_IDLE;
      end
      TX_GUARD: begin
        if (bif.tick && tx_tk_r == SAMPLE_TICK && tx_bit_r == 8'h00 && !txi_s2_r) begin
          nack_seen_nxt = 1'b1;
        end
        if (tx_end) begin
          tx_bit_nxt = tx_bit_r + 8'h01;
          if (tx_bit_r == (nack_seen_r ? 8'h02 : 8'h01)) begin
            tx_bit_nxt = 8'h00;
            nack_seen_nxt = 1'b0;
            tx_st_nxt = TX_IDLE;
            rep_cnt_nxt = 3'h0;
            if (nack_seen_r && rep_lim != 3'h0) begin
              if (rep_cnt_r != rep_lim) begin
                rep_cnt_nxt = rep_cnt_r + 3'h1;
                tx_par_nxt = (^tx_char_r) ^ odd;
                tx_st_nxt = TX_START;
              end else begin
                rep_evt = 1'b1;
              end
            end
          end
        end
      end
      TX_BRK: if (tx_end) begin
        if (brk_stop_r && tx_bit_r >= BRK_LAST_BIT) begin
          tx_bit_nxt = 8'h00;
          brk_end = 1'b1;
          tx_st_nxt = TX_HOLD;
        end else if (tx_bit_r < BRK_LAST_BIT) begin
          tx_bit_nxt = tx_bit_r + 8'h01;
        end
      end
      TX_HOLD: if (tx_end) begin
        tx_bit_nxt = tx_bit_r + 8'h01;
        if (tx_bit_r == hold_last) tx_st_nxt = TX_IDLE;
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
    case (tx_st_r)
      TX_START: tx_line = 1'b0;
      TX_BRK: tx_line = 1'b0;
      TX_DATA: tx_line = msb_first_select ? tx_char_r[3'h7 - tx_bit_r[2:0]] : tx_char_r[tx_bit_r[2:0]];
      TX_PAR: tx_line = tx_par_r;
      default: tx_line = 1'b1;
    endcase
    tx_drive = ~sc | ((tx_st_r != TX_IDLE) & (tx_st_r != TX_GUARD));
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_st_r <= TX_IDLE;
      tx_tk_r <= 4'h0;
      tx_bit_r <= 8'h00;
      tx_char_r <= 8'h00;
      tx_par_r <= 1'b0;
      rep_cnt_r <= 3'h0;
      nack_seen_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_tk_r <= tx_tk_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_char_r <= tx_char_nxt;
      tx_par_r <= tx_par_nxt;
      rep_cnt_r <= rep_cnt_nxt;
      nack_seen_r <= nack_seen_nxt;
    end
  end

  // receiver
  logic [3:0] rx_tk_r, rx_tk_nxt;
  logic [2:0] rx_bit_r, rx_bit_nxt, rx_idx;
  logic [7:0] rx_data_r, rx_data_nxt;
  logic [1:0] hi_r, hi_nxt;
  logic rx_pbit_r, rx_pbit_nxt, rx_in, rx_mid, rx_end, rx_perr;
  assign rx_in = sc ? txi_s2_r : rxd_s2_r;
  assign rx_mid = bif.tick & (rx_tk_r == SAMPLE_TICK);
  assign rx_end = bif.tick & (rx_tk_r == LAST_TICK);
  assign rx_idx = msb_first_select ? 3'h7 - rx_bit_r : rx_bit_r;
  assign rx_perr = par_en & (rx_pbit_r ^ (^rx_data_r) ^ odd);

  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_tk_nxt = bif.tick ? rx_tk_r + 4'h1 : rx_tk_r;
    rx_bit_nxt = rx_bit_r;
    rx_data_nxt = rx_data_r;
    rx_pbit_nxt = rx_pbit_r;
    rhr_nxt = rhr_r;
    hi_nxt = hi_r;
    rx_rdy_set = 1'b0;
    brk_evt = 1'b0;
    frame_evt = 1'b0;
    par_evt = 1'b0;
    nack_inhibit_evt = 1'b0;
    err_evt = 1'b0;
    case (rx_st_r)
      RX_IDLE: begin
        rx_tk_nxt = 4'h0;
        rx_bit_nxt = 3'h0;
        rx_pbit_nxt = 1'b0;
        if (rx_en_r && !rx_in) rx_st_nxt = RX_START;
      end
      RX_START: begin
        if (rx_mid && rx_in) rx_st_nxt = RX_IDLE;
        else if (rx_end) rx_st_nxt = RX_DATA;
      end
      RX_DATA: begin
        if (rx_mid) rx_data_nxt[rx_idx] = rx_in;
        if (rx_end) begin
          rx_bit_nxt = rx_bit_r + 3'h1;
          if (rx_bit_r == 3'h7) rx_st_nxt = par_en ? RX_PAR : RX_STOP;
        end
      end
      RX_PAR: begin
        if (rx_mid) rx_pbit_nxt = rx_in;
        if (rx_end) begin
          rx_st_nxt = RX_STOP;
          if (t0 && rx_perr && !nack_inhibit) begin
            rx_st_nxt = RX_NACK;
            par_evt = 1'b1;
            err_evt = 1'b1;
          end
        end
      end
      RX_NACK: if (rx_end) rx_st_nxt = RX_IDLE;
      RX_STOP: if (rx_mid) begin
        hi_nxt = 2'h0;
        if (rx_data_r == 8'h00 && !(par_en && rx_pbit_r) && !rx_in) begin
          brk_evt = 1'b1;
          rx_st_nxt = RX_BRKEND;
        end else begin
          rx_st_nxt = RX_IDLE;
          frame_evt = ~rx_in;
          err_evt = ~rx_in | rx_perr;
          rhr_nxt = rx_data_r;
          rx_rdy_set = 1'b1;
          if (rx_perr && t0) begin
            nack_inhibit_evt = 1'b1;
            rx_rdy_set = 1'b0;
          end else if (rx_perr) begin
            par_evt = 1'b1;
          end
        end
      end
      RX_BRKEND: if (bif.tick) begin
        hi_nxt = 2'h0;
        if (rx_in) begin
          hi_nxt = hi_r + 2'h1;
          if (hi_r + 2'h1 >= (sync ? BRK_END_SYNC : BRK_END_ASYNC)) begin
            brk_evt = 1'b1;
            rx_st_nxt = RX_IDLE;
          end
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_st_r <= RX_IDLE;
      rx_tk_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_data_r <= 8'h00;
      rx_pbit_r <= 1'b0;
      rhr_r <= 8'h00;
      hi_r <= 2'h0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_tk_r <= rx_tk_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_data_r <= rx_data_nxt;
      rx_pbit_r <= rx_pbit_nxt;
      rhr_r <= rhr_nxt;
      hi_r <= hi_nxt;
    end
  end

  // pin drivers
  logic txd_out_nxt, txd_oe_n_nxt, rts_nxt;
  always_comb begin
    txd_out_nxt = (rx_st_r == RX_NACK) ? 1'b0 : tx_line;
    txd_oe_n_nxt = ~(tx_drive | (rx_st_r == RX_NACK));
    rts_nxt = hs & (~rx_en_r | rx_dma_buffer_full);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txd_out <= 1'b1;
      txd_oe_n <= 1'b0;
      rts <= 1'b0;
    end else begin
      txd_out <= txd_out_nxt;
      txd_oe_n <= txd_oe_n_nxt;
      rts <= rts_nxt;
    end
  end
endmodule : usart_core
`default_nettype wire

// File: usart_core_props.sv
`timescale 1ns/1ps
`default_nettype none
module usart_core_props
  import usart_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic txd_out,
  input wire logic txd_oe_n,
  input wire logic rts,
  input wire logic rx_dma_buffer_full
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [3:0] mode_r;
  logic nack_inhibit_r, txen_r, rxen_r, brk_r;
  logic [15:0] baud_r;
  logic [19:0] lo_r, hi_r;
  wire wr_ok = psel && penable && pwrite;
  wire hs = mode_r == MODE_HANDSHAKE;
  wire card = mode_r == MODE_SC_T0 || mode_r == MODE_SC_T1;
  wire [19:0] hold_min = 20'(baud_r) * 20'hc0 - 20'h4;
  // shadow of the configuration plus run lengths of the transmit line
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {mode_r, nack_inhibit_r, txen_r, rxen_r, brk_r, baud_r, lo_r, hi_r} <= '0;
    end else begin
      if (wr_ok && paddr == OFF_MODE) begin
        mode_r <= pwdata[MR_MODE_LSB +: 4];
        nack_inhibit_r <= pwdata[MR_NACK_INHIBIT];
      end
      if (wr_ok && paddr == OFF_BAUD) baud_r <= pwdata[15:0];
      if (wr_ok && paddr == OFF_CTRL) begin
        txen_r <= (txen_r || pwdata[CR_TX_EN]) && !pwdata[CR_TX_DIS];
        rxen_r <= (rxen_r || pwdata[CR_RX_EN]) && !pwdata[CR_RX_DIS];
      end
      lo_r <= txd_out ? 20'h0 : lo_r + 20'h1;
      hi_r <= txd_out ? hi_r + 20'h1 : 20'h0;
      if (!txd_out) brk_r <= lo_r > 20'(baud_r) * 20'ha8;
    end
  end
  rts_block_a: assert property ((hs && (!rxen_r || rx_dma_buffer_full)) [*3] |-> rts)
    else $error("rts low while reception blocked");
  rts_open_a: assert property ((hs && rxen_r && !rx_dma_buffer_full) [*3] |-> !rts)
    else $error("rts high while reception open");
  card_float_a: assert property ((card && !txen_r && !rxen_r) [*3] |-> txd_oe_n)
    else $error("io driven with transmitter off");
  nack_drive_a: assert property (card && !txen_r && $fell(txd_oe_n) |-> (!txd_oe_n && !txd_out) [*8])
    else $error("nack not a driven low level");
  no_nack_a: assert property (card && !txen_r && nack_inhibit_r |-> !$fell(txd_oe_n))
    else $error("nack driven while inhibited");
  brk_hold_a: assert property (baud_r != 16'h0 && brk_r && hi_r != 20'h0 && hi_r < hold_min |-> txd_out)
    else $error("line left high too briefly after break");
  err_phase_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("slave error outside access phase");
  errcnt_width_a: assert property (psel && penable && !pwrite && paddr == OFF_ERRCNT |-> prdata[31:8] == 24'h0)
    else $error("error count above eight bits");
endmodule : usart_core_props
bind usart_core usart_core_props chk (.clock, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
  .prdata, .pslverr, .txd_out, .txd_oe_n, .rts, .rx_dma_buffer_full);
`default_nettype wire

// File: serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
  parameter int BITC = 32
) (
  input wire logic clock,
  input wire logic line_in,
  output logic pout,
  output logic pdrv_n
);
  logic nack_seen;
  initial begin
    pout = 1'b1;
    pdrv_n = 1'b1;
    nack_seen = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic free_line;
    pdrv_n <= 1'b1;
  endtask : free_line
  // card mode leaves the guard to the pull-up and looks for a nack there
  task automatic send(input logic [7:0] d, input logic pbad, input logic stopv, input logic card);
    logic [9:0] f;
    f = {(^d) ^ pbad, d, 1'b0};
    pdrv_n <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      pout <= f[i];
      cyc(BITC);
    end
    if (card) begin
      pdrv_n <= 1'b1;
      cyc(BITC / 2);
      nack_seen = !line_in;
      cyc(BITC * 3 / 2 + (nack_seen ? BITC : 0));
    end else begin
      pout <= stopv;
      cyc(BITC);
      pdrv_n <= stopv;
    end
  endtask : send
  task automatic recv(output logic [7:0] d, output logic par_ok, input logic nack_req);
    logic [8:0] s;
    while (line_in !== 1'b1) @(posedge clock);
    while (line_in !== 1'b0) @(posedge clock);
    cyc(BITC / 2);
    for (int i = 0; i < 9; i++) begin
      cyc(BITC);
      s[i] = line_in;
    end
    d = s[7:0];
    par_ok = ^s == 1'b0;
    if (nack_req) begin
      cyc(BITC / 2);
      pout <= 1'b0;
      pdrv_n <= 1'b0;
      cyc(BITC);
      pdrv_n <= 1'b1;
    end
  endtask : recv
endmodule : serial_peer
`default_nettype wire

// File: usart_break_handshake_smartcard_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usart_break_handshake_smartcard_tb
  import usart_pkg::*;
;
  localparam int BAUD = 2;
  localparam int BITC = 16 * BAUD;
  logic clock, resetn, psel, penable, pwrite, pready, pslverr, txd_out, txd_oe_n, sck, rts, cts;
  logic rx_dma_buffer_full, er, ok, pout, pdrv_n;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, rd;
  int error_cnt, checked;
  wire io = !txd_oe_n ? txd_out : (!pdrv_n ? pout : 1'b1);
  wire rxd = pdrv_n ? 1'b1 : pout;
  usart_core dut (.clock, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .rxd, .txd_in(io), .txd_out, .txd_oe_n, .sck, .rts, .cts, .rx_dma_buffer_full);
  serial_peer #(.BITC(BITC)) peer (.clock, .line_in(io), .pout, .pdrv_n);
  always #2.5 clock = ~clock;
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk1
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) error_cnt++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk32(rd, exp);
  endtask : rdc
  task automatic st(input int bi, input logic v);
    apb(1'b0, OFF_STAT, 32'h0);
    chk1(rd[bi], v);
  endtask : st
  task automatic cmd(input int bi);
    wr(OFF_CTRL, 32'h1 << bi);
  endtask : cmd
  task automatic bits(input int n);
    repeat (n * BITC) @(posedge clock);
  endtask : bits
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  initial begin
    {clock, resetn, psel, penable, pwrite, cts, rx_dma_buffer_full} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    rdc(OFF_MODE, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk1(er, 1'b1);
    chk32(rd, 32'h0);
    wr(OFF_BAUD, 32'(BAUD));
    cmd(CR_TX_EN);
    cmd(CR_BRK_STOP);
    bits(2);
    chk1(io, 1'b1);
    fork
      peer.recv(b, ok, 1'b0);
      begin
        wr(OFF_THR, 32'h11);
        repeat (4) @(posedge clock);
        cmd(CR_BRK_START);
        wr(OFF_THR, 32'h22);
        st(SR_TX_FREE, 1'b0);
      end
    join
    chk32(b, 32'h11);
    bits(3);
    chk1(io, 1'b0);
    st(SR_TX_FREE, 1'b1);
    st(SR_TX_EMPTY, 1'b0);
    bits(12);
    cmd(CR_BRK_STOP);
    fork
      peer.recv(b, ok, 1'b0);
      begin
        bits(1);
        wr(OFF_THR, 32'h00);
        bits(6);
        chk1(io, 1'b1);
      end
    join
    chk32(b, 32'h00);
    cmd(CR_RX_EN);
    peer.send(8'h00, 1'b0, 1'b0, 1'b0);
    bits(2);
    st(SR_RX_BRK, 1'b1);
    st(SR_FRAME, 1'b0);
    cmd(CR_STAT_CLR);
    st(SR_RX_BRK, 1'b0);
    peer.free_line();
    bits(1);
    st(SR_RX_BRK, 1'b1);
    cmd(CR_RX_DIS);
    wr(OFF_MODE, 32'(MODE_HANDSHAKE));
    repeat (4) @(posedge clock);
    chk1(rts, 1'b1);
    cmd(CR_RX_EN);
    repeat (4) @(posedge clock);
    chk1(rts, 1'b0);
    rx_dma_buffer_full <= 1'b1;
    repeat (4) @(posedge clock);
    chk1(rts, 1'b1);
    rx_dma_buffer_full <= 1'b0;
    repeat (4) @(posedge clock);
    chk1(rts, 1'b0);
    cts <= 1'b1;
    repeat (4) @(posedge clock);
    wr(OFF_THR, 32'h5a);
    bits(2);
    chk1(io, 1'b1);
    st(SR_TX_FREE, 1'b0);
    fork
      peer.recv(b, ok, 1'b0);
      cts <= 1'b0;
    join
    chk32(b, 32'h5a);
    fork
      peer.recv(b, ok, 1'b0);
      begin
        wr(OFF_THR, 32'h5b);
        bits(3);
        cts <= 1'b1;
      end
    join
    chk32(b, 32'h5b);
    cts <= 1'b0;
    bits(2);
    wr(OFF_CTRL, 32'h1 << CR_TX_DIS | 32'h1 << CR_RX_DIS);
    wr(OFF_MODE, 32'(MODE_SC_T0));
    bits(1);
    cmd(CR_RX_EN);
    apb(1'b0, OFF_ERRCNT, 32'h0);
    peer.send(8'h3c, 1'b0, 1'b1, 1'b1);
    chk1(peer.nack_seen, 1'b0);
    st(SR_RX_READY, 1'b1);
    rdc(OFF_RHR, 32'h3c);
    peer.send(8'h77, 1'b1, 1'b1, 1'b1);
    chk1(peer.nack_seen, 1'b1);
    st(SR_PARITY, 1'b1);
    st(SR_RX_READY, 1'b0);
    rdc(OFF_RHR, 32'h3c);
    rdc(OFF_ERRCNT, 32'h1);
    rdc(OFF_ERRCNT, 32'h0);
    cmd(CR_STAT_CLR);
    st(SR_PARITY, 1'b0);
    wr(OFF_MODE, 32'(MODE_SC_T0) | 32'h1 << MR_NACK_INHIBIT);
    peer.send(8'h99, 1'b1, 1'b1, 1'b1);
    chk1(peer.nack_seen, 1'b0);
    st(SR_NACK, 1'b1);
    st(SR_RX_READY, 1'b0);
    rdc(OFF_RHR, 32'h99);
    cmd(CR_NACK_CLR);
    st(SR_NACK, 1'b0);
    cmd(CR_RX_DIS);
    wr(OFF_MODE, 32'(MODE_SC_T0) | 32'h2 << MR_REP_LSB);
    cmd(CR_TX_EN);
    fork
      for (int i = 0; i < 3; i++) begin
        peer.recv(b, ok, 1'b1);
        chk32(b, 32'h42);
      end
      wr(OFF_THR, 32'h42);
    join
    bits(3);
    st(SR_REPEAT, 1'b1);
    cmd(CR_REP_CLR);
    st(SR_REPEAT, 1'b0);
    fork
      begin
        peer.recv(b, ok, 1'b1);
        peer.recv(b, ok, 1'b0);
      end
      wr(OFF_THR, 32'h43);
    join
    chk32(b, 32'h43);
    bits(3);
    st(SR_REPEAT, 1'b0);
    cmd(CR_TX_DIS);
    wr(OFF_MODE, 32'(MODE_SC_T1) | 32'h1 << MR_MSB_FIRST_SELECT);
    cmd(CR_TX_EN);
    ok = sck;
    repeat (2) @(posedge clock);
    chk1(sck, !ok);
    fork
      peer.recv(b, ok, 1'b0);
      wr(OFF_THR, 32'h01);
    join
    chk32(b, 32'h80);
    chk1(ok, 1'b1);
    stop_test();
  end
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule : usart_break_handshake_smartcard_tb
`default_nettype wire
